// >>> rtl/cis_top.sv
// Charger input supervisor top: APB registers, power path, throttle, interrupt.
// Assumes APB master on mclk and comparator inputs synchronous to mclk.
//
// Chosen here: the APB register port and the register offsets.
`timescale 1ns/100ps
`include "cis_map.svh"
module cis_top
   import cis_pkg::*;
(
   input wire logic mclk,
   input wire logic rst_n,
   input wire logic [11:0] paddr,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic vin_above_uvlo,
   input wire logic vin_above_uvlo_release,
   input wire logic [3:0] vin_above_ovp,
   input wire logic vin_above_normal,
   input wire logic system_supply_rail_sag,
   input wire logic input_overload,
   input wire logic ac_mode_select_pin,
   input wire logic charge_level_pin,
   output logic [1:0] sys_path_sel,
   output logic charge_enable,
   output logic [11:0] input_current_limit_ma,
   output logic [11:0] charge_current_ma,
   output logic [2:0] charge_current_div,
   output logic [11:0] precharge_current_ma,
   output logic [6:0] precharge_percent,
   output logic charge_current_resistor_pin_en,
   output logic [3:0] dynamic_charge_throttle,
   output logic interrupt_out_n
);

   // ----------------------------------------------------------------
   // Helpers
   // ----------------------------------------------------------------

   // Word compare; low two address bits ignored
   function automatic logic addr_is(input logic [11:0] a, input logic [11:0] b);
      addr_is = (a[11:2] == b[11:2]);
   endfunction

   function automatic logic addr_hit(input logic [11:0] a);
      addr_hit = addr_is(a, `CIS_ADDR_CTRL) || addr_is(a, `CIS_ADDR_IRQ_MASK) ||
                 addr_is(a, `CIS_ADDR_IRQ_STAT) || addr_is(a, `CIS_ADDR_STATUS);
   endfunction

   localparam logic [8:0] STEP_RELOAD = 9'(`CIS_THR_STEP_CYC - 1);

   cis_top_st_t st_ff;
   cis_top_st_t nxt_st;
   cis_sup_if sup ();

   logic apb_setup;
   logic apb_access;
   logic wr_fire;
   logic rd_fire;
   logic [1:0] evt_vec;
   logic [1:0] clr_vec;
   logic irq_pending;
   logic [31:0] status_word;
   logic [31:0] rd_word;
   logic step_tick;

   // ----------------------------------------------------------------
   // Submodules
   // ----------------------------------------------------------------
   cis_input_mon u_mon (
      .mclk(mclk),
      .rst_n(rst_n),
      .vin_above_uvlo(vin_above_uvlo),
      .vin_above_uvlo_release(vin_above_uvlo_release),
      .vin_above_ovp(vin_above_ovp),
      .vin_above_normal(vin_above_normal),
      .sup(sup.mon)
   );

   cis_mode_sel u_mode (
      .mclk(mclk),
      .rst_n(rst_n),
      .ac_mode_select_pin(ac_mode_select_pin),
      .charge_level_pin(charge_level_pin),
      .sup(sup.mode)
   );

   assign sup.ovp_sel = st_ff.ovp_sel;

   // ----------------------------------------------------------------
   // APB phase decode
   // ----------------------------------------------------------------

   // Zero wait: pready raised in every access phase
   always_comb begin
      apb_setup = psel && !penable;
      apb_access = psel && penable && st_ff.pready;
      wr_fire = apb_access && pwrite;
      rd_fire = apb_access && !pwrite;
   end

   // ----------------------------------------------------------------
   // Status words
   // ----------------------------------------------------------------

   // Interrupt status bit is the OR of enabled pending events
   always_comb begin
      evt_vec = '0;
      evt_vec[`CIS_IRQ_CON_BIT] = sup.evt_connect;
      evt_vec[`CIS_IRQ_DIS_BIT] = sup.evt_disconnect;
      irq_pending = |(st_ff.sticky & st_ff.mask);
      status_word = '0;
      status_word[`CIS_ST_VALID_BIT] = sup.input_valid;
      status_word[`CIS_ST_AC_BIT] = sup.ac_level;
      status_word[`CIS_ST_IRQ_BIT] = irq_pending;
      status_word[`CIS_ST_UV_BIT] = sup.uv_lock;
      status_word[`CIS_ST_OV_BIT] = sup.ov_lock;
      status_word[`CIS_ST_CHG_BIT] = st_ff.chg_en;
      status_word[`CIS_ST_PATH_LSB +: 2] = st_ff.path;
   end

   // Read mux; unmapped addresses return zero
   always_comb begin
      rd_word = '0;
      if (addr_is(paddr, `CIS_ADDR_CTRL)) begin
         rd_word[1:0] = st_ff.ovp_sel;
      end else if (addr_is(paddr, `CIS_ADDR_IRQ_MASK)) begin
         rd_word[1:0] = st_ff.mask;
      end else if (addr_is(paddr, `CIS_ADDR_IRQ_STAT)) begin
         rd_word[1:0] = st_ff.sticky;
      end else if (addr_is(paddr, `CIS_ADDR_STATUS)) begin
         rd_word = status_word;
      end
   end

   // ----------------------------------------------------------------
   // Sticky event clears
   // ----------------------------------------------------------------

   // Status read clears all; write-one clears single bits
   always_comb begin
      clr_vec = '0;
      if (rd_fire && addr_is(paddr, `CIS_ADDR_STATUS)) begin
         clr_vec = 2'h3;
      end
      if (wr_fire && addr_is(paddr, `CIS_ADDR_IRQ_STAT)) begin
         clr_vec = clr_vec | pwdata[1:0];
      end
   end

   // ----------------------------------------------------------------
   // Throttle step divider
   // ----------------------------------------------------------------
   always_comb begin
      step_tick = (st_ff.step_cnt == 9'h000);
   end

   // ----------------------------------------------------------------
   // Next state
   // ----------------------------------------------------------------
   always_comb begin
      nxt_st = st_ff;

      // Bus answer, captured in setup and shown in access
      nxt_st.pready = apb_setup;
      nxt_st.pslverr = apb_setup && !addr_hit(paddr);
      nxt_st.prdata = (apb_setup && !pwrite) ? rd_word : 32'h0000_0000;

      // Writable control
      if (wr_fire && addr_is(paddr, `CIS_ADDR_CTRL)) begin
         nxt_st.ovp_sel = pwdata[1:0];
      end
      if (wr_fire && addr_is(paddr, `CIS_ADDR_IRQ_MASK)) begin
         nxt_st.mask = pwdata[1:0];
      end

      // A new event beats a clear in the same cycle
      nxt_st.sticky = (st_ff.sticky & ~clr_vec) | evt_vec;

      // Interrupt pin follows pending status in the same cycle, from next-state values
      nxt_st.irq_n = !(|(nxt_st.sticky & nxt_st.mask));

      // Power path selection
      if (!sup.input_valid) begin
         nxt_st.path = CIS_PATH_BATT;
      end else if (input_overload) begin
         nxt_st.path = CIS_PATH_BOTH;
      end else begin
         nxt_st.path = CIS_PATH_INPUT;
      end

      // Charging needs a valid input and both lockouts clear
      nxt_st.chg_en = sup.input_valid && !sup.uv_lock && !sup.ov_lock;

      // Throttle walks up while the rail sags, back down once it recovers;
      // a slow step keeps the loop from hunting against the rail filter
      nxt_st.step_cnt = step_tick ? STEP_RELOAD : st_ff.step_cnt - 9'h001;
      if (!st_ff.chg_en) begin
         nxt_st.thr_lvl = 4'h0;
      end else if (step_tick) begin
         if (system_supply_rail_sag && st_ff.thr_lvl != 4'hf) begin
            nxt_st.thr_lvl = st_ff.thr_lvl + 4'h1;
         end else if (!system_supply_rail_sag && st_ff.thr_lvl != 4'h0) begin
            nxt_st.thr_lvl = st_ff.thr_lvl - 4'h1;
         end
      end
   end

   // ----------------------------------------------------------------
   // State register
   // ----------------------------------------------------------------
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         st_ff <= '0;
         st_ff.ovp_sel <= `CIS_CTRL_RST;
         st_ff.mask <= `CIS_MASK_RST;
         st_ff.irq_n <= 1'b1;
         st_ff.path <= CIS_PATH_BATT;
      end else begin
         st_ff <= nxt_st;
      end
   end

   // ----------------------------------------------------------------
   // Outputs
   // ----------------------------------------------------------------
   assign prdata = st_ff.prdata;
   assign pready = st_ff.pready;
   assign pslverr = st_ff.pslverr;
   assign sys_path_sel = st_ff.path;
   assign charge_enable = st_ff.chg_en;
   assign dynamic_charge_throttle = st_ff.thr_lvl;
   assign interrupt_out_n = st_ff.irq_n;
   // Mode values come straight from the mode module's flops
   assign input_current_limit_ma = sup.ilim_ma;
   assign charge_current_ma = sup.chg_ma;
   assign charge_current_div = sup.chg_div;
   assign precharge_current_ma = sup.pre_ma;
   assign precharge_percent = sup.pre_pct;
   assign charge_current_resistor_pin_en = sup.use_charge_current_resistor_pin;
endmodule

// >>> rtl/cis_map.svh
// Constants for the charger input supervisor: addresses, fields, resets, levels.
// Assumes inclusion by every design file that needs them; definitions only.
`ifndef CIS_MAP_SVH
`define CIS_MAP_SVH

// ----------------------------------------------------------------
// Register byte addresses
// ----------------------------------------------------------------
`define CIS_ADDR_CTRL 12'h000
`define CIS_ADDR_IRQ_MASK 12'h004
`define CIS_ADDR_IRQ_STAT 12'h008
`define CIS_ADDR_STATUS 12'h00c

// ----------------------------------------------------------------
// Field positions and reset values
// ----------------------------------------------------------------
`define CIS_IRQ_CON_BIT 0
`define CIS_IRQ_DIS_BIT 1
`define CIS_ST_VALID_BIT 0
`define CIS_ST_AC_BIT 1
`define CIS_ST_IRQ_BIT 2
`define CIS_ST_UV_BIT 3
`define CIS_ST_OV_BIT 4
`define CIS_ST_CHG_BIT 5
`define CIS_ST_PATH_LSB 6
`define CIS_CTRL_RST 2'h0
`define CIS_MASK_RST 2'h0

// ----------------------------------------------------------------
// Analog levels behind the comparator inputs (mV), for reference
// ----------------------------------------------------------------
`define CIS_OVP_SEL0_MV 6600
`define CIS_OVP_SEL1_MV 7000
`define CIS_OVP_SEL2_MV 7500
`define CIS_OVP_SEL3_MV 8000
`define CIS_OVP_RELEASE_MV 6000
`define CIS_UVLO_MV 3500
`define CIS_UVLO_HYST_MV 500
`define CIS_SAG_MV 200
`define CIS_AC_THRESH_MV 1200

// ----------------------------------------------------------------
// Current settings (mA unless named otherwise)
// ----------------------------------------------------------------
`define CIS_ILIM_USB_LO_MA 12'h064
`define CIS_ILIM_USB_HI_MA 12'h1c2
`define CIS_ILIM_AC_MA 12'h7d0
`define CIS_CHG_USB_LO_MA 12'h05a
`define CIS_CHG_USB_HI_MA 12'h1c2
`define CIS_PRE_USB_MA 12'h02d
`define CIS_AC_LOW_DIV 3'h5
`define CIS_AC_HIGH_DIV 3'h1
`define CIS_PRE_AC_PCT 7'h0a

// ----------------------------------------------------------------
// Throttle step timing
// ----------------------------------------------------------------
`define CIS_CLK_PERIOD_NS 25
`define CIS_THR_STEP_NS 10000
`define CIS_THR_STEP_CYC ((`CIS_THR_STEP_NS + `CIS_CLK_PERIOD_NS - 1) / `CIS_CLK_PERIOD_NS)

`endif

// >>> rtl/cis_pkg.sv
// Types shared by the charger input supervisor modules.
// Assumes nothing beyond a SystemVerilog compiler.
package cis_pkg;

   // ----------------------------------------------------------------
   // System power path
   // ----------------------------------------------------------------
   typedef enum logic [1:0] {
      CIS_PATH_BATT = 2'b00,
      CIS_PATH_INPUT = 2'b01,
      CIS_PATH_BOTH = 2'b10
   } cis_path_t;

   // ----------------------------------------------------------------
   // Module state records
   // ----------------------------------------------------------------
   typedef struct packed {
      logic uv_lock;
      logic ov_lock;
      logic valid;
      logic evt_con;
      logic evt_dis;
   } cis_mon_st_t;

   typedef struct packed {
      logic ac_level;
      logic [11:0] ilim_ma;
      logic [11:0] chg_ma;
      logic [2:0] chg_div;
      logic [11:0] pre_ma;
      logic [6:0] pre_pct;
      logic use_charge_current_resistor_pin;
   } cis_mode_st_t;

   typedef struct packed {
      logic [1:0] ovp_sel;
      logic [1:0] mask;
      logic [1:0] sticky;
      logic [31:0] prdata;
      logic pready;
      logic pslverr;
      logic irq_n;
      cis_path_t path;
      logic chg_en;
      logic [3:0] thr_lvl;
      logic [8:0] step_cnt;
   } cis_top_st_t;

endpackage

// >>> rtl/cis_sup_if.sv
// Carrier between the supervisor top and its monitor and mode modules.
// Assumes all three sit on the same clock.
`timescale 1ns/100ps
interface cis_sup_if;
   logic [1:0] ovp_sel;
   logic input_valid;
   logic uv_lock;
   logic ov_lock;
   logic evt_connect;
   logic evt_disconnect;
   logic ac_level;
   logic [11:0] ilim_ma;
   logic [11:0] chg_ma;
   logic [2:0] chg_div;
   logic [11:0] pre_ma;
   logic [6:0] pre_pct;
   logic use_charge_current_resistor_pin;

   modport mon (
      input ovp_sel,
      output input_valid,
      output uv_lock,
      output ov_lock,
      output evt_connect,
      output evt_disconnect
   );

   modport mode (
      output ac_level,
      output ilim_ma,
      output chg_ma,
      output chg_div,
      output pre_ma,
      output pre_pct,
      output use_charge_current_resistor_pin
   );

   modport top (
      output ovp_sel,
      input input_valid,
      input uv_lock,
      input ov_lock,
      input evt_connect,
      input evt_disconnect,
      input ac_level,
      input ilim_ma,
      input chg_ma,
      input chg_div,
      input pre_ma,
      input pre_pct,
      input use_charge_current_resistor_pin
   );
endinterface

// >>> rtl/cis_input_mon.sv
// Input supply monitor: validity, under- and over-voltage lockouts, events.
// Assumes comparator levels already synchronous to mclk.
`timescale 1ns/100ps
`include "cis_map.svh"
module cis_input_mon
   import cis_pkg::*;
(
   input wire logic mclk,
   input wire logic rst_n,
   input wire logic vin_above_uvlo,
   input wire logic vin_above_uvlo_release,
   input wire logic [3:0] vin_above_ovp,
   input wire logic vin_above_normal,
   cis_sup_if.mon sup
);
   cis_mon_st_t st_ff;
   cis_mon_st_t nxt_st;
   logic over_now;

   // ----------------------------------------------------------------
   // Lockouts and validity
   // ----------------------------------------------------------------
   always_comb begin
      nxt_st = st_ff;
      over_now = vin_above_ovp[sup.ovp_sel];
      // Under-voltage lock, released only past the hysteresis level
      if (!vin_above_uvlo) begin
         nxt_st.uv_lock = 1'b1;
      end else if (vin_above_uvlo_release) begin
         nxt_st.uv_lock = 1'b0;
      end
      // Over-voltage lock held until input is back under 6.0V
      if (over_now) begin
         nxt_st.ov_lock = 1'b1;
      end else if (!vin_above_normal) begin
         nxt_st.ov_lock = 1'b0;
      end
      nxt_st.valid = vin_above_uvlo && !over_now;
      nxt_st.evt_con = nxt_st.valid && !st_ff.valid;
      nxt_st.evt_dis = !nxt_st.valid && st_ff.valid;
   end

   // Lock starts set so charging waits for a proven input
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         st_ff <= '0;
         st_ff.uv_lock <= 1'b1;
      end else begin
         st_ff <= nxt_st;
      end
   end

   assign sup.input_valid = st_ff.valid;
   assign sup.uv_lock = st_ff.uv_lock;
   assign sup.ov_lock = st_ff.ov_lock;
   assign sup.evt_connect = st_ff.evt_con;
   assign sup.evt_disconnect = st_ff.evt_dis;
endmodule

// >>> rtl/cis_mode_sel.sv
// Current mode selection from the AC-select and charge-level pins.
// Assumes both pins arrive as logic levels synchronous to mclk.
`timescale 1ns/100ps
`include "cis_map.svh"
module cis_mode_sel
   import cis_pkg::*;
(
   input wire logic mclk,
   input wire logic rst_n,
   input wire logic ac_mode_select_pin,
   input wire logic charge_level_pin,
   cis_sup_if.mode sup
);
   cis_mode_st_t st_ff;
   cis_mode_st_t nxt_st;

   // ----------------------------------------------------------------
   // Mode table
   // ----------------------------------------------------------------
   always_comb begin
      nxt_st = st_ff;
      nxt_st.ac_level = ac_mode_select_pin;
      if (ac_mode_select_pin) begin
         // AC: resistor sets current, pins only scale it
         nxt_st.ilim_ma = `CIS_ILIM_AC_MA;
         nxt_st.use_charge_current_resistor_pin = 1'b1;
         nxt_st.chg_ma = 12'h000;
         nxt_st.chg_div = charge_level_pin ? `CIS_AC_HIGH_DIV : `CIS_AC_LOW_DIV;
         nxt_st.pre_ma = 12'h000;
         nxt_st.pre_pct = `CIS_PRE_AC_PCT;
      end else begin
         nxt_st.ilim_ma = charge_level_pin ? `CIS_ILIM_USB_HI_MA : `CIS_ILIM_USB_LO_MA;
         nxt_st.use_charge_current_resistor_pin = 1'b0;
         nxt_st.chg_ma = charge_level_pin ? `CIS_CHG_USB_HI_MA : `CIS_CHG_USB_LO_MA;
         nxt_st.chg_div = `CIS_AC_HIGH_DIV;
         nxt_st.pre_ma = `CIS_PRE_USB_MA;
         nxt_st.pre_pct = 7'h00;
      end
   end

   // Reset to the most restrictive USB-low setting
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         st_ff <= '0;
         st_ff.ilim_ma <= `CIS_ILIM_USB_LO_MA;
         st_ff.chg_ma <= `CIS_CHG_USB_LO_MA;
         st_ff.chg_div <= `CIS_AC_HIGH_DIV;
         st_ff.pre_ma <= `CIS_PRE_USB_MA;
      end else begin
         st_ff <= nxt_st;
      end
   end

   assign sup.ac_level = st_ff.ac_level;
   assign sup.ilim_ma = st_ff.ilim_ma;
   assign sup.chg_ma = st_ff.chg_ma;
   assign sup.chg_div = st_ff.chg_div;
   assign sup.pre_ma = st_ff.pre_ma;
   assign sup.pre_pct = st_ff.pre_pct;
   assign sup.use_charge_current_resistor_pin = st_ff.use_charge_current_resistor_pin;
endmodule

// >>> sim/cis_supply_model.sv
// Input supply model: a supply voltage in mV becomes comparator levels.
// Assumes the bench moves vin_mv off the clock edge; levels follow at once.
`timescale 1ns/100ps
`include "cis_map.svh"
module cis_supply_model (
   input int vin_mv,
   output logic vin_above_uvlo,
   output logic vin_above_uvlo_release,
   output logic [3:0] vin_above_ovp,
   output logic vin_above_normal
);
   // ----
   // Comparator ladder, one level per analog threshold
   // ----
   assign vin_above_uvlo = vin_mv > `CIS_UVLO_MV;
   assign vin_above_uvlo_release = vin_mv > (`CIS_UVLO_MV + `CIS_UVLO_HYST_MV);
   assign vin_above_ovp = {vin_mv > `CIS_OVP_SEL3_MV, vin_mv > `CIS_OVP_SEL2_MV,
      vin_mv > `CIS_OVP_SEL1_MV, vin_mv > `CIS_OVP_SEL0_MV};
   assign vin_above_normal = vin_mv > `CIS_OVP_RELEASE_MV;
endmodule

// >>> sim/cis_top_monitor.sv
// Port assertions for cis_top.
// Assumes one clock domain; bound onto every cis_top.
`timescale 1ns/100ps
module cis_top_monitor (
   input wire logic mclk,
   input wire logic rst_n,
   input wire logic [11:0] paddr,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic pready,
   input wire logic pslverr,
   input wire logic vin_above_uvlo,
   input wire logic [3:0] vin_above_ovp,
   input wire logic ac_mode_select_pin,
   input wire logic charge_level_pin,
   input wire logic charge_enable,
   input wire logic [2:0] charge_current_div,
   input wire logic charge_current_resistor_pin_en,
   input wire logic [3:0] dynamic_charge_throttle,
   input wire logic interrupt_out_n
);
   logic [2:0] quiet_ff;
   default clocking @(posedge mclk); endclocking
   default disable iff (!rst_n);
   // ----
   // Quiet count: a status read only releases the irq with no event in flight
   // ----
   always_ff @(posedge mclk) begin
      if (!rst_n || $changed(vin_above_uvlo) || $changed(vin_above_ovp) || (psel && pwrite))
         quiet_ff <= 3'h0;
      else if (quiet_ff != 3'h7)
         quiet_ff <= quiet_ff + 3'h1;
   end
   sequence s_acc;
      psel && penable && pready;
   endsequence
   sequence s_stat_rd;
      s_acc ##0 (!pwrite && paddr[11:2] == 10'h003 && quiet_ff > 3'h3);
   endsequence
   property p_ans;
      psel && !penable |=> pready;
   endproperty
   a_ans: assert property (p_ans) else $error("apb answer late");
   property p_err;
      s_acc |-> pslverr == (paddr[11:2] > 10'h003);
   endproperty
   a_err: assert property (p_err) else $error("apb error flag wrong");
   property p_ovp_off;
      vin_above_ovp[3] |=> ##1 !charge_enable;
   endproperty
   a_ovp_off: assert property (p_ovp_off) else $error("charging above ovp");
   property p_uv_off;
      !vin_above_uvlo |=> ##1 !charge_enable;
   endproperty
   a_uv_off: assert property (p_uv_off) else $error("charging below uvlo");
   property p_ac;
      $past(rst_n) |-> charge_current_resistor_pin_en == $past(ac_mode_select_pin);
   endproperty
   a_ac: assert property (p_ac) else $error("ac mode wrong");
   property p_div;
      $past(rst_n) |-> charge_current_div ==
         (($past(ac_mode_select_pin) && !$past(charge_level_pin)) ? 3'h5 : 3'h1);
   endproperty
   a_div: assert property (p_div) else $error("divider wrong");
   property p_thr_zero;
      (!charge_enable) [*3] |-> dynamic_charge_throttle == 4'h0;
   endproperty
   a_thr_zero: assert property (p_thr_zero) else $error("throttle not cleared");
   property p_thr_step;
      $past(rst_n) && dynamic_charge_throttle > $past(dynamic_charge_throttle)
         |-> dynamic_charge_throttle == $past(dynamic_charge_throttle) + 4'h1;
   endproperty
   a_thr_step: assert property (p_thr_step) else $error("throttle jumped");
   property p_rd_rel;
      s_stat_rd |=> interrupt_out_n;
   endproperty
   a_rd_rel: assert property (p_rd_rel) else $error("irq held after read");
endmodule
bind cis_top cis_top_monitor u_chk (.*);

// >>> sim/cis_top_tb_top.sv
// Bench for cis_top: APB tasks, supply model, pin stimulus, self-check.
// Assumes the design, the supply model and the monitor compile first.
`timescale 1ns/100ps
`include "cis_map.svh"
module cis_top_tb_top;
   logic mclk, rst_n, psel, penable, pwrite, pready, pslverr, e;
   logic system_supply_rail_sag, input_overload, ac_mode_select_pin, charge_level_pin;
   logic vin_above_uvlo, vin_above_uvlo_release, vin_above_normal, charge_enable;
   logic charge_current_resistor_pin_en, interrupt_out_n;
   logic [11:0] paddr, input_current_limit_ma, charge_current_ma, precharge_current_ma;
   logic [31:0] pwdata, prdata, q;
   logic [3:0] vin_above_ovp, dynamic_charge_throttle;
   logic [1:0] sys_path_sel;
   logic [2:0] charge_current_div;
   logic [6:0] precharge_percent;
   int vin_mv, n_fail, checks, cyc;
   int thr[4] = '{`CIS_OVP_SEL0_MV, `CIS_OVP_SEL1_MV, `CIS_OVP_SEL2_MV, `CIS_OVP_SEL3_MV};
   cis_top dut (.*);
   cis_supply_model supply (.*);
   // ----
   // Clock, timeout and shared tasks
   // ----
   initial begin
      mclk = 1'b0;
      forever #12.5 mclk = ~mclk;
   end
   always @(posedge mclk) begin
      cyc++;
      if (cyc == 20000) begin
         n_fail++;
         end_sim();
      end
   end
   task automatic end_sim();
      if (n_fail == 0 && checks > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask
   task automatic chk(input string nm, input logic [31:0] ex, input logic [31:0] got);
      checks++;
      if (got !== ex) begin
         n_fail++;
         $display("BAD %s exp %h got %h", nm, ex, got);
      end
   endtask
   // One APB transfer; holds the request until pready is sampled high
   task automatic apb(input logic [11:0] a, input logic w, input logic [31:0] d);
      paddr <= a;
      pwrite <= w;
      pwdata <= d;
      psel <= 1'b1;
      @(posedge mclk);
      penable <= 1'b1;
      // No wait-state count assumed; only the bench timeout ends a hang
      do begin
         @(posedge mclk);
      end while (pready !== 1'b1);
      q = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge mclk);
   endtask
   task automatic rdm(input logic [11:0] a, input logic [31:0] m, input logic [31:0] ex);
      apb(a, 1'b0, 32'h0);
      chk($sformatf("reg %h", a), ex, q & m);
   endtask
   // ----
   // Main sequence
   // ----
   initial begin
      rst_n = 1'b0;
      {psel, penable, pwrite, paddr, pwdata} = '0;
      {system_supply_rail_sag, input_overload, ac_mode_select_pin, charge_level_pin} = '0;
      vin_mv = 0;
      repeat (5) @(posedge mclk);
      rst_n <= 1'b1;
      @(posedge mclk);
      chk("irq_rst", 1, interrupt_out_n);
      rdm(`CIS_ADDR_CTRL, 32'h3, 32'h0);
      rdm(`CIS_ADDR_IRQ_MASK, 32'h3, 32'h0);
      // Every pin mode, level pin as the low bit
      for (int i = 0; i < 4; i++) begin
         ac_mode_select_pin <= i[1];
         charge_level_pin <= i[0];
         repeat (3) @(posedge mclk);
         chk("ilim", i[1] ? 12'h7d0 : (i[0] ? 12'h1c2 : 12'h064), input_current_limit_ma);
         chk("chg", i[1] ? 12'h0 : (i[0] ? 12'h1c2 : 12'h05a), charge_current_ma);
         chk("mode", {i == 2 ? 3'h5 : 3'h1, i[1], i[1] ? 12'h0 : 12'h02d, i[1] ? 7'h0a : 7'h0},
            {charge_current_div, charge_current_resistor_pin_en, precharge_current_ma,
            precharge_percent});
         rdm(`CIS_ADDR_STATUS, 32'h2, {30'h0, i[1], 1'b0});
      end
      // Connect held off by the mask, raised by unmasking, then cleared by a status read
      vin_mv <= 5000;
      repeat (8) @(posedge mclk);
      chk("irq_masked", 1, interrupt_out_n);
      chk("path_in", 2'h1, sys_path_sel);
      apb(`CIS_ADDR_IRQ_MASK, 1'b1, 32'h1);
      repeat (2) @(posedge mclk);
      chk("irq_con", 0, interrupt_out_n);
      rdm(`CIS_ADDR_STATUS, 32'hff, 32'h67);
      repeat (2) @(posedge mclk);
      chk("irq_clr", 1, interrupt_out_n);
      rdm(`CIS_ADDR_STATUS, 32'h4, 32'h0);
      input_overload <= 1'b1;
      repeat (3) @(posedge mclk);
      rdm(`CIS_ADDR_STATUS, 32'hc0, 32'h80);
      chk("path_both", 2'h2, sys_path_sel);
      input_overload <= 1'b0;
      // Disconnect, cleared by writing a one
      apb(`CIS_ADDR_IRQ_MASK, 1'b1, 32'h2);
      vin_mv <= 0;
      repeat (8) @(posedge mclk);
      chk("irq_dis", 0, interrupt_out_n);
      chk("path_bat", 2'h0, sys_path_sel);
      rdm(`CIS_ADDR_IRQ_STAT, 32'h3, 32'h2);
      apb(`CIS_ADDR_IRQ_STAT, 1'b1, 32'h2);
      repeat (2) @(posedge mclk);
      chk("irq_w1c", 1, interrupt_out_n);
      rdm(`CIS_ADDR_STATUS, 32'hff, 32'h0a);
      // Under-voltage hysteresis: valid again before charging restarts
      vin_mv <= 3800;
      repeat (6) @(posedge mclk);
      rdm(`CIS_ADDR_STATUS, 32'h29, 32'h09);
      vin_mv <= 4200;
      repeat (6) @(posedge mclk);
      rdm(`CIS_ADDR_STATUS, 32'h29, 32'h21);
      // Each over-voltage select; lock holds until below the release level
      for (int s = 0; s < 4; s++) begin
         apb(`CIS_ADDR_CTRL, 1'b1, s);
         vin_mv <= thr[s] + 100;
         repeat (6) @(posedge mclk);
         rdm(`CIS_ADDR_STATUS, 32'h31, 32'h10);
         vin_mv <= thr[s] - 100;
         repeat (6) @(posedge mclk);
         rdm(`CIS_ADDR_STATUS, 32'h31, 32'h11);
         vin_mv <= 5000;
         repeat (6) @(posedge mclk);
         rdm(`CIS_ADDR_STATUS, 32'h31, 32'h21);
      end
      // Unmapped address refused
      apb(12'h010, 1'b1, 32'h3);
      chk("err_w", 1, e);
      apb(12'h010, 1'b0, 32'h0);
      chk("err_r", 1, e);
      chk("err_q", 0, q);
      // Rail sag ramps the throttle to its top, loss of input clears it
      system_supply_rail_sag <= 1'b1;
      repeat (`CIS_THR_STEP_CYC * 16 + 10) @(posedge mclk);
      chk("thr_max", 15, dynamic_charge_throttle);
      // One step period plus one edge holds exactly one step
      system_supply_rail_sag <= 1'b0;
      repeat (`CIS_THR_STEP_CYC + 1) @(posedge mclk);
      chk("thr_down", 14, dynamic_charge_throttle);
      vin_mv <= 0;
      repeat (6) @(posedge mclk);
      chk("thr_off", 0, dynamic_charge_throttle);
      end_sim();
   end
endmodule
